/* core/serial_ctrl.sv */
// Summary of operation
// [R1] DMA data read clears receive full flag
// [R2] DMA read alone leaves other flags unchanged
// [R3] in DMA mode data read clears full
// [R4] receive irq enable off disables DMA service
// [R5] status read arms, data read clears errors
// [R6] overrun stays, later bytes still load
// [R7] wait mode blocks CPU register access
// [R8] enabled CPU requests raise wake request
// [R9] DMA service works during wait mode
// [R10] stop mode freezes state, resumes after
// [R11] break with clear allowed: clears stick
// [R12] break without allow: flags untouched
// [R13] enabled module forces transmit pin output
// [R14] enabled module forces receive pin input
// [R15] loop mode routes transmitter to receiver
// [R16] enable gates logic; clearing sets tx flags
// [R17] inversion flips every transmitted level
// [R18] length bit selects nine or eight bits
// [R19] wake bit selects address mark or idle
// [R20] idle type picks where counting starts
// [R21] reset clears control register one
// [R22] both enables route full flag to DMA
// [R23] overrun keeps old data, drops new
// [R24] software masks receive irq during error service
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module serial_ctrl (
  input wire logic REF_CLK, // 250 MHz clock
  input wire logic NRST, // sync reset, active low
  input wire logic [2:0] ADDR, // register index
  input wire logic [7:0] WDATA, // write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [7:0] RDATA, // read data, next cycle
  input wire logic DMA_RD, // DMA read of data register
  output logic [7:0] DMA_DATA, // DMA read data, next cycle
  output logic DMA_RX_REQ, // receive DMA service request
  output logic DMA_TX_REQ, // transmit DMA service request
  output logic IRQ_RX, // receiver CPU request
  output logic IRQ_TX, // transmitter CPU request
  output logic IRQ_ERR, // error CPU request
  output logic WAKE_REQ, // any enabled CPU request
  input wire logic WAIT_MODE, // CPU in wait
  input wire logic STOP_MODE, // CPU in stop
  input wire logic DEBUG_BREAK, // debug break state
  input wire logic BREAK_CLEAR_ALLOW, // flag clears allowed in break
  input wire logic PORT_DIR_TX, // port direction, transmit pin
  input wire logic PORT_DATA_TX, // port data, transmit pin
  input wire logic PORT_DIR_RX, // port direction, receive pin
  input wire logic PORT_DATA_RX, // port data, receive pin
  input wire logic SER_IN, // receive pin level
  output logic SER_OUT, // transmit pin drive value
  output logic SER_OUT_OE_N, // transmit pin enable, low drives
  output logic SER_IN_PIN_OUT, // receive pin drive value
  output logic SER_IN_PIN_OE_N // receive pin enable, low drives
);
  import serial_ctrl_pkg::*;

  ctrl_one_t c1_r;
  ctrl_two_t c2_r;
  ctrl_three_t c3_r;
  logic [7:0] baud_r, div_r, rx_data_r, tx_buf_r, arm_r, stat_r;
  logic [5:0] rx_flag_r;
  logic [1:0] tx_flag_r; // tx empty, tx done
  logic [1:0] stat2_r;
  logic [1:0] sync_r;
  logic os_tick, run, cpu_wr, cpu_rd, guard, stat_rd, data_rd, dma_mode;
  logic clr_full, rx_in, en;
  logic [7:0] clr;
  logic [8:0] rx_sh_r;
  logic rx_prev_r, idle_seen_r, rx_done, rx_smp, idle_det, wake_hit;

  function automatic logic par8(input logic [8:0] v, input logic nine);
    par8 = nine ? ^v[7:0] : ^v[6:0];
  endfunction

  assign run = ~STOP_MODE; // R10
  assign stat_r = {tx_flag_r, rx_flag_r};
  assign en = c1_r.module_enable;
  assign cpu_wr = WR & ~WAIT_MODE & run; // R7
  assign cpu_rd = RD & ~WAIT_MODE & run; // R7
  assign guard = DEBUG_BREAK & ~BREAK_CLEAR_ALLOW; // R12
  assign stat_rd = cpu_rd & (ADDR == STAT1_ADDR) & ~guard;
  // DMA reads proceed in wait mode
  assign data_rd = ((cpu_rd & (ADDR == DATA_ADDR)) | (DMA_RD & run))
                   & ~guard; // R9
  assign dma_mode = c2_r.receive_irq_enable
                    & c3_r.dma_receive_service_enable; // R4
  assign clr_full = data_rd & (arm_r[ST_RX_FULL] | dma_mode | DMA_RD); // R1 R3
  always_comb begin
    clr = data_rd ? arm_r : 8'h00; // R5 R2
    clr[ST_RX_FULL] = clr_full;
    clr[ST_TX_EMPTY] = 1'b0;
    clr[ST_TX_DONE] = 1'b0;
  end

  // control registers
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      c1_r <= CTRL1_RST; // R21
      c2_r <= CTRL2_RST;
      c3_r <= CTRL3_RST;
      baud_r <= BAUD_RST;
    end else if (run) begin
      if (cpu_wr && ADDR == CTRL1_ADDR) begin
        c1_r <= WDATA;
        if (!WDATA[6]) begin
          c2_r.tx_irq_enable <= 1'b0; // R16
          c2_r.tx_done_irq_enable <= 1'b0; // R16
        end
      end else if (cpu_wr && ADDR == CTRL2_ADDR) begin
        c2_r <= WDATA;
        if (!en) begin
          c2_r.tx_enable <= c2_r.tx_enable;
          c2_r.rx_enable <= c2_r.rx_enable;
        end
      end else if (cpu_wr && ADDR == CTRL3_ADDR) begin
        c3_r[6:0] <= WDATA[6:0];
      end else if (cpu_wr && ADDR == BAUD_ADDR) begin
        baud_r <= WDATA;
      end
      if (wake_hit)
        c2_r.rx_standby <= 1'b0; // R19
      if (rx_done)
        c3_r.rx_ninth <= rx_sh_r[8];
    end
  end

  // baud divider, gated by module enable
  always_ff @(posedge REF_CLK) begin
    if (!NRST)
      div_r <= 8'h00;
    else if (run) begin
      if (!en || div_r == 8'h00)
        div_r <= baud_r; // R16
      else
        div_r <= div_r - 8'h01;
    end
  end
  assign os_tick = en & (div_r == 8'h00); // R16

  // receive pin synchroniser
  always_ff @(posedge REF_CLK) begin
    if (!NRST)
      sync_r <= 2'b11;
    else
      sync_r <= {sync_r[0], SER_IN};
  end

  // receiver
  rx_state_t rx_st_r;
  logic [3:0] rx_ph_r, rx_bit_r, idle_cnt_r;
  logic [3:0] char_len;
  logic [3:0] tx_cnt_r;
  logic [10:0] tx_sh_r;
  logic tx_line;

  assign tx_line = (tx_cnt_r != 4'h0) ? tx_sh_r[0] : 1'b1;
  assign rx_in = c1_r.loopback_select ? tx_line : sync_r[1]; // R15
  assign char_len = c1_r.char_len_nine ? LEN_9BIT : LEN_8BIT; // R18
  assign rx_smp = os_tick & c2_r.rx_enable & (rx_ph_r == OS_LAST);
  assign rx_done = rx_smp & (rx_st_r == RX_STOP);
  assign idle_det = rx_smp & (rx_st_r == RX_IDLE) & rx_in & ~idle_seen_r
                    & (idle_cnt_r == char_len - 4'h1);
  assign wake_hit = c2_r.rx_standby &
                    (c1_r.wake_addr_mark ? rx_done & rx_sh_r[8]
                                         : idle_det); // R19

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      rx_st_r <= RX_IDLE;
      rx_ph_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 9'h000;
      rx_prev_r <= 1'b1;
    end else if (run) begin
      if (!en || !c2_r.rx_enable) begin
        rx_st_r <= RX_IDLE;
      end else if (os_tick) begin
        rx_ph_r <= rx_ph_r + 4'h1;
        rx_prev_r <= rx_in;
        case (rx_st_r)
          RX_IDLE: begin
            if (!rx_in) begin
              rx_st_r <= RX_START;
              rx_ph_r <= 4'h0;
            end
          end
          RX_START: begin
            if (rx_ph_r == OS_HALF) begin
              rx_ph_r <= 4'h0;
              rx_bit_r <= 4'h0;
              rx_st_r <= rx_in ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_ph_r == OS_LAST) begin
              rx_sh_r <= {rx_in, rx_sh_r[8:1]};
              rx_bit_r <= rx_bit_r + 4'h1;
              if (rx_bit_r == char_len - 4'h3)
                rx_st_r <= RX_STOP; // R18
            end
          end
          RX_STOP: begin
            if (rx_ph_r == OS_LAST)
              rx_st_r <= RX_IDLE;
          end
          default: rx_st_r <= RX_IDLE;
        endcase
      end
    end
  end

  // idle line counting
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      idle_cnt_r <= 4'h0;
      idle_seen_r <= 1'b0;
    end else if (run) begin
      if (rx_smp) begin
        if (!rx_in)
          idle_cnt_r <= 4'h0;
        else if (rx_st_r == RX_STOP && c1_r.idle_count_start_select)
          idle_cnt_r <= 4'h0; // R20
        else if (idle_cnt_r != LEN_9BIT)
          idle_cnt_r <= idle_cnt_r + 4'h1; // R20
        if (idle_det)
          idle_seen_r <= 1'b1;
      end
      if (rx_st_r == RX_START)
        idle_seen_r <= 1'b0;
    end
  end

  // receive data and status flags
  logic accept, full_eff, rx_noise, rx_par, rx_brk;
  logic [7:0] set;
  assign accept = ~c2_r.rx_standby | wake_hit;
  assign full_eff = stat_r[ST_RX_FULL] & ~clr_full;
  assign rx_noise = rx_smp & (rx_st_r != RX_IDLE) & (rx_in != rx_prev_r);
  assign rx_par = c1_r.parity_enable &
                  ((c1_r.char_len_nine ? rx_sh_r[8] : rx_sh_r[7])
                   ^ par8({rx_sh_r[7:0], 1'b0} >> 1, 1'b1)
                   ^ c1_r.parity_odd);
  assign rx_brk = rx_done & ~rx_in & (rx_sh_r == 9'h000);

  always_comb begin
    set = 8'h00;
    set[ST_RX_FULL] = rx_done & accept & ~full_eff; // R6
    set[ST_OVERRUN] = rx_done & accept & full_eff; // R23
    set[ST_IDLE] = idle_det & ~c2_r.rx_standby;
    set[ST_NOISE] = rx_noise & accept;
    set[ST_FRAMING] = rx_done & accept & ~rx_in;
    set[ST_PARITY] = rx_done & accept & rx_par;
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      rx_data_r <= 8'h00;
      rx_flag_r <= 6'h00;
      stat2_r <= 2'b00;
      arm_r <= 8'h00;
    end else if (run) begin
      if (set[ST_RX_FULL])
        rx_data_r <= c1_r.char_len_nine ? rx_sh_r[7:0] : rx_sh_r[8:1];
      // set wins over clear
      rx_flag_r <= (rx_flag_r & ~clr[5:0]) | set[5:0]; // R5 R11
      if (rx_brk)
        stat2_r[ST2_BREAK] <= 1'b1;
      else if (rx_smp && rx_in && rx_st_r == RX_IDLE && !guard)
        stat2_r[ST2_BREAK] <= 1'b0;
      stat2_r[ST2_RX_BUSY] <= (rx_st_r != RX_IDLE);
      if (stat_rd)
        arm_r <= {2'b00, stat_r[5:0]}; // R5
      else if (data_rd)
        arm_r <= 8'h00; // R5
    end
  end

  // transmitter
  logic [3:0] tx_ph_r;
  logic tx_pend_r, te_prev_r, tx_load, tx_wr;
  logic [8:0] tx_char;
  assign tx_wr = cpu_wr & (ADDR == DATA_ADDR);
  assign tx_load = os_tick & c2_r.tx_enable & (tx_cnt_r == 4'h0)
                   & (c2_r.send_break | tx_pend_r | ~stat_r[ST_TX_EMPTY]);
  always_comb begin
    tx_char = {c3_r.tx_ninth, tx_buf_r};
    if (c1_r.parity_enable && c1_r.char_len_nine)
      tx_char[8] = par8(tx_char, 1'b1) ^ c1_r.parity_odd;
    else if (c1_r.parity_enable)
      tx_char[7] = par8(tx_char, 1'b0) ^ c1_r.parity_odd;
    if (!c1_r.char_len_nine)
      tx_char[8] = 1'b1;
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      tx_buf_r <= 8'h00;
      tx_sh_r <= 11'h7FF;
      tx_cnt_r <= 4'h0;
      tx_ph_r <= 4'h0;
      tx_pend_r <= 1'b0;
      te_prev_r <= 1'b0;
      tx_flag_r <= 2'b11;
    end else if (run) begin
      te_prev_r <= c2_r.tx_enable;
      if (tx_wr)
        tx_buf_r <= WDATA;
      if (c2_r.tx_enable && !te_prev_r)
        tx_pend_r <= 1'b1;
      if (tx_load) begin
        tx_ph_r <= 4'h0;
        tx_cnt_r <= char_len;
        if (c2_r.send_break)
          tx_sh_r <= 11'h000;
        else if (tx_pend_r) begin
          tx_sh_r <= 11'h7FF;
          tx_pend_r <= 1'b0;
        end else
          tx_sh_r <= {1'b1, tx_char, 1'b0};
      end else if (os_tick && tx_cnt_r != 4'h0) begin
        tx_ph_r <= tx_ph_r + 4'h1;
        if (tx_ph_r == OS_LAST) begin
          tx_sh_r <= {1'b1, tx_sh_r[10:1]};
          tx_cnt_r <= tx_cnt_r - 4'h1;
        end
      end
      if (!en)
        tx_flag_r <= 2'b11; // R16
      else begin
        if (tx_wr)
          tx_flag_r[1] <= 1'b0;
        else if (tx_load && !c2_r.send_break && !tx_pend_r)
          tx_flag_r[1] <= 1'b1;
        tx_flag_r[0] <= ~tx_wr & (tx_cnt_r == 4'h0)
                              & stat_r[ST_TX_EMPTY] & ~tx_pend_r;
      end
    end
  end

  // requests, pins and read data
  logic irq_rx, irq_tx, irq_err;
  assign irq_rx = c2_r.receive_irq_enable & ~c3_r.dma_receive_service_enable
                  & ~c2_r.rx_standby & (stat_r[ST_RX_FULL]
                  | (c2_r.idle_irq_enable & stat_r[ST_IDLE]));
  assign irq_tx = (c2_r.tx_irq_enable & ~c3_r.dma_tx_enable
                   & stat_r[ST_TX_EMPTY])
                  | (c2_r.tx_done_irq_enable & stat_r[ST_TX_DONE]);
  assign irq_err = (c3_r.overrun_irq_enable & stat_r[ST_OVERRUN])
                   | (c3_r.noise_irq_enable & stat_r[ST_NOISE])
                   | (c3_r.framing_irq_enable & stat_r[ST_FRAMING])
                   | (c3_r.parity_irq_enable & stat_r[ST_PARITY]);

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      IRQ_RX <= 1'b0;
      IRQ_TX <= 1'b0;
      IRQ_ERR <= 1'b0;
      WAKE_REQ <= 1'b0;
      DMA_RX_REQ <= 1'b0;
      DMA_TX_REQ <= 1'b0;
      SER_OUT <= 1'b1;
      SER_OUT_OE_N <= 1'b1;
      SER_IN_PIN_OUT <= 1'b0;
      SER_IN_PIN_OE_N <= 1'b1;
    end else begin
      IRQ_RX <= irq_rx;
      IRQ_TX <= irq_tx;
      IRQ_ERR <= irq_err;
      WAKE_REQ <= irq_rx | irq_tx | irq_err; // R8
      DMA_RX_REQ <= dma_mode & stat_r[ST_RX_FULL]; // R22
      DMA_TX_REQ <= c2_r.tx_irq_enable & c3_r.dma_tx_enable
                    & stat_r[ST_TX_EMPTY];
      SER_OUT <= en ? tx_line ^ c1_r.transmit_invert : PORT_DATA_TX; // R17
      SER_OUT_OE_N <= en ? 1'b0 : ~PORT_DIR_TX; // R13
      SER_IN_PIN_OUT <= PORT_DATA_RX;
      SER_IN_PIN_OE_N <= en ? 1'b1 : ~PORT_DIR_RX; // R14
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      RDATA <= 8'h00;
      DMA_DATA <= 8'h00;
    end else if (run) begin
      if (DMA_RD)
        DMA_DATA <= rx_data_r;
      if (!cpu_rd)
        RDATA <= 8'h00;
      else if (ADDR == CTRL1_ADDR)
        RDATA <= c1_r;
      else if (ADDR == CTRL2_ADDR)
        RDATA <= c2_r;
      else if (ADDR == CTRL3_ADDR)
        RDATA <= c3_r;
      else if (ADDR == STAT1_ADDR)
        RDATA <= stat_r;
      else if (ADDR == STAT2_ADDR)
        RDATA <= {6'h00, stat2_r};
      else if (ADDR == DATA_ADDR)
        RDATA <= rx_data_r;
      else if (ADDR == BAUD_ADDR)
        RDATA <= baud_r;
      else
        RDATA <= 8'h00;
    end
  end

endmodule
`default_nettype wire

/* core/serial_ctrl_pkg.sv */
package serial_ctrl_pkg;

  // register indices on the plain register port
  localparam logic [2:0] CTRL1_ADDR = 3'h0;
  localparam logic [2:0] CTRL2_ADDR = 3'h1;
  localparam logic [2:0] CTRL3_ADDR = 3'h2;
  localparam logic [2:0] STAT1_ADDR = 3'h3;
  localparam logic [2:0] STAT2_ADDR = 3'h4;
  localparam logic [2:0] DATA_ADDR = 3'h5;
  localparam logic [2:0] BAUD_ADDR = 3'h6;

  // reset values
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] CTRL3_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h0F;

  // status register one bit positions
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_TX_DONE = 6;
  localparam int ST_RX_FULL = 5;
  localparam int ST_IDLE = 4;
  localparam int ST_OVERRUN = 3;
  localparam int ST_NOISE = 2;
  localparam int ST_FRAMING = 1;
  localparam int ST_PARITY = 0;

  // status register two bit positions
  localparam int ST2_BREAK = 1;
  localparam int ST2_RX_BUSY = 0;

  // timing counts, in oversample ticks and bit times
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam logic [3:0] OS_HALF = 4'h7;
  localparam logic [3:0] LEN_8BIT = 4'hA;
  localparam logic [3:0] LEN_9BIT = 4'hB;

  typedef struct packed {
    logic loopback_select;
    logic module_enable;
    logic transmit_invert;
    logic char_len_nine;
    logic wake_addr_mark;
    logic idle_count_start_select;
    logic parity_enable;
    logic parity_odd;
  } ctrl_one_t;

  typedef struct packed {
    logic tx_irq_enable;
    logic tx_done_irq_enable;
    logic receive_irq_enable;
    logic idle_irq_enable;
    logic tx_enable;
    logic rx_enable;
    logic rx_standby;
    logic send_break;
  } ctrl_two_t;

  typedef struct packed {
    logic rx_ninth;
    logic tx_ninth;
    logic dma_receive_service_enable;
    logic dma_tx_enable;
    logic overrun_irq_enable;
    logic noise_irq_enable;
    logic framing_irq_enable;
    logic parity_irq_enable;
  } ctrl_three_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage

/* dv/serial_ctrl_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module serial_ctrl_sva (
  input wire logic REF_CLK, // clock
  input wire logic NRST, // reset
  input wire logic RD, // read strobe
  input wire logic WR, // write strobe
  input wire logic WAIT_MODE, // wait state
  input wire logic DMA_RD, // dma read
  input wire logic [7:0] RDATA, // read data
  input wire logic DMA_RX_REQ, // dma request
  input wire logic IRQ_RX, // rx request
  input wire logic IRQ_TX, // tx request
  input wire logic IRQ_ERR, // error request
  input wire logic WAKE_REQ, // wake request
  input wire logic DEBUG_BREAK, // break state
  input wire logic PORT_DIR_TX, // tx pin direction
  input wire logic SER_OUT_OE_N, // tx pin enable
  input wire logic SER_IN_PIN_OE_N // rx pin enable
);
  logic rd_wait;
  assign rd_wait = RD & WAIT_MODE;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  a_rdata_idle_zero: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not zero outside read answer");
  a_wait_blocks_read: assert property ($past(rd_wait) |-> RDATA == 8'h00)
    else $error("register read answered in wait mode");
  a_dma_clears_full: assert property (
    (DMA_RD && DMA_RX_REQ && !DEBUG_BREAK) |-> ##2 !DMA_RX_REQ)
    else $error("dma read left receive request up");
  a_dma_not_cpu: assert property (DMA_RX_REQ |-> !IRQ_RX)
    else $error("cpu receive request beside dma request");
  a_wake_follows: assert property (
    (IRQ_RX || IRQ_TX || IRQ_ERR) |-> ##[0:1] WAKE_REQ)
    else $error("enabled request without wake");
  a_pins_owned: assert property (
    (!PORT_DIR_TX && !SER_OUT_OE_N) |-> SER_IN_PIN_OE_N)
    else $error("receive pin driven while module owns pins");
  a_req_fall_read: assert property ($fell(DMA_RX_REQ) |->
    $past(DMA_RD) || $past(DMA_RD, 2) || $past(RD) || $past(RD, 2) ||
    $past(WR) || $past(WR, 2))
    else $error("receive request dropped without access");
  a_err_fall_read: assert property ($fell(IRQ_ERR) |->
    $past(DMA_RD) || $past(DMA_RD, 2) || $past(RD) || $past(RD, 2) ||
    $past(WR) || $past(WR, 2))
    else $error("error request dropped without access");
  c_dma_read: cover property (DMA_RD && DMA_RX_REQ);
  c_err_raised: cover property ($rose(IRQ_ERR));
  c_wait_read: cover property (rd_wait);
endmodule
bind serial_ctrl serial_ctrl_sva serial_ctrl_sva_i (.REF_CLK(REF_CLK),
  .NRST(NRST), .RD(RD), .WR(WR), .WAIT_MODE(WAIT_MODE), .DMA_RD(DMA_RD),
  .RDATA(RDATA), .DMA_RX_REQ(DMA_RX_REQ), .IRQ_RX(IRQ_RX),
  .IRQ_TX(IRQ_TX), .IRQ_ERR(IRQ_ERR), .WAKE_REQ(WAKE_REQ),
  .DEBUG_BREAK(DEBUG_BREAK), .PORT_DIR_TX(PORT_DIR_TX),
  .SER_OUT_OE_N(SER_OUT_OE_N), .SER_IN_PIN_OE_N(SER_IN_PIN_OE_N));
`default_nettype wire

/* dv/serial_line_model.sv */
`timescale 1ns/1ns
`default_nettype none
module serial_line_model #(
  parameter int BIT = 16
) (
  input wire logic REF_CLK, // clock
  output logic LINE // receive pin, idles high
);
  initial LINE = 1'b1;
  // lsb first frame, gap gives prompt or slow sender
  task send(input logic [7:0] d, input logic stop_ok, input int gap);
    logic [9:0] f;
    f = {stop_ok, d, 1'b0};
    repeat (gap) @(posedge REF_CLK);
    for (int i = 0; i < 10; i++) begin
      @(posedge REF_CLK);
      LINE <= f[i];
      repeat (BIT - 1) @(posedge REF_CLK);
    end
    @(posedge REF_CLK);
    LINE <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* dv/tb_serial_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_serial_ctrl;
  import serial_ctrl_pkg::*;
  logic REF_CLK = 0, NRST = 0, WR = 0, RD = 0, DMA_RD = 0;
  logic WAIT_MODE = 0, STOP_MODE = 0, DEBUG_BREAK = 0;
  logic BREAK_CLEAR_ALLOW = 0;
  logic IRQ_ERR, WAKE_REQ, SER_IN_PIN_OUT;
  logic [2:0] ADDR = 3'h0;
  logic [7:0] WDATA = 8'h00;
  logic [7:0] RDATA, DMA_DATA, a, b, c;
  logic DMA_RX_REQ, SER_IN, SER_OUT, SER_OUT_OE_N, SER_IN_PIN_OE_N;
  int errors = 0, n_compared = 0, seed = 32'h630c;
  logic [15:0] rq[$];
  logic [7:0] dq[$];
  logic rd_p = 0, dma_p = 0;
  always #2 REF_CLK = ~REF_CLK;
  serial_ctrl serial_ctrl_i (.REF_CLK(REF_CLK), .NRST(NRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .DMA_RD(DMA_RD),
    .DMA_DATA(DMA_DATA), .DMA_RX_REQ(DMA_RX_REQ), .DMA_TX_REQ(),
    .IRQ_RX(), .IRQ_TX(), .IRQ_ERR(IRQ_ERR), .WAKE_REQ(WAKE_REQ),
    .WAIT_MODE(WAIT_MODE), .STOP_MODE(STOP_MODE), .DEBUG_BREAK(DEBUG_BREAK),
    .BREAK_CLEAR_ALLOW(BREAK_CLEAR_ALLOW), .PORT_DIR_TX(1'b0),
    .PORT_DATA_TX(1'b0), .PORT_DIR_RX(1'b1), .PORT_DATA_RX(1'b0),
    .SER_IN(SER_IN), .SER_OUT(SER_OUT), .SER_OUT_OE_N(SER_OUT_OE_N),
    .SER_IN_PIN_OUT(SER_IN_PIN_OUT),
    .SER_IN_PIN_OE_N(SER_IN_PIN_OE_N));
  serial_line_model #(.BIT(16)) serial_line_model_i (.REF_CLK(REF_CLK),
    .LINE(SER_IN));
  task print_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task check(input logic [7:0] got, input logic [7:0] exp, m);
    n_compared++;
    if ((got & m) !== (exp & m)) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] ad, input logic [7:0] d);
    @(posedge REF_CLK);
    ADDR <= ad;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge REF_CLK);
    WR <= 1'b0;
  endtask
  task rd(input logic [2:0] ad, input logic [7:0] m, e);
    rq.push_back({m, e});
    @(posedge REF_CLK);
    ADDR <= ad;
    RD <= 1'b1;
    @(posedge REF_CLK);
    RD <= 1'b0;
  endtask
  task dma(input logic [7:0] e);
    dq.push_back(e);
    @(posedge REF_CLK);
    DMA_RD <= 1'b1;
    @(posedge REF_CLK);
    DMA_RD <= 1'b0;
  endtask
  task wait_req();
    int i;
    for (i = 0; i < 400 && DMA_RX_REQ !== 1'b1; i++) @(posedge REF_CLK);
    if (i == 400) begin
      errors++;
      $display("ERROR %0t: no receive request", $time);
    end
  endtask
  task rx(input logic [7:0] d, input logic ok, input int gap);
    serial_line_model_i.send(d, ok, gap);
    wait_req();
  endtask
  // answers are compared in the cycle after each strobe
  always @(posedge REF_CLK) begin
    logic [15:0] x;
    if (rd_p) begin
      x = rq.pop_front();
      check(RDATA, x[7:0], x[15:8]);
    end
    if (dma_p) check(DMA_DATA, dq.pop_front(), 8'hFF);
    rd_p <= RD;
    dma_p <= DMA_RD;
  end
  initial begin
    repeat (30000) @(posedge REF_CLK);
    errors++;
    $display("ERROR %0t: watchdog expired", $time);
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge REF_CLK);
    NRST <= 1'b1;
    rd(CTRL1_ADDR, 8'hFF, CTRL1_RST);
    rd(STAT1_ADDR, 8'hFF, 8'hC0);
    rd(3'h7, 8'hFF, 8'h00);
    wr(CTRL1_ADDR, 8'h60);
    wr(BAUD_ADDR, 8'h00);
    repeat (3) @(posedge REF_CLK);
    check({7'h00, SER_OUT}, 8'h00, 8'h01);
    check({7'h00, SER_OUT_OE_N}, 8'h00, 8'h01);
    check({7'h00, SER_IN_PIN_OE_N}, 8'h01, 8'h01);
    wr(CTRL1_ADDR, 8'h40);
    wr(CTRL2_ADDR, 8'h2C);
    wr(CTRL3_ADDR, 8'h28);
    rd(CTRL3_ADDR, 8'h7F, 8'h28);
    $display("test setup done");
    a = 8'($random(seed));
    rx(a, 1'b1, 0);
    dma(a);
    rd(STAT1_ADDR, 8'h20, 8'h00);
    b = 8'($random(seed));
    rx(b, 1'b1, 40);
    rd(DATA_ADDR, 8'hFF, b);
    rd(STAT1_ADDR, 8'h2B, 8'h00);
    $display("test dma receive done");
    c = 8'($random(seed)) | 8'h01;
    rx(c, 1'b0, 20);
    dma(c);
    rd(STAT1_ADDR, 8'h22, 8'h02);
    DEBUG_BREAK <= 1'b1;
    rd(DATA_ADDR, 8'hFF, c);
    rd(STAT1_ADDR, 8'h02, 8'h02);
    DEBUG_BREAK <= 1'b0;
    rd(DATA_ADDR, 8'hFF, c);
    rd(STAT1_ADDR, 8'h02, 8'h00);
    $display("test framing clear done");
    a = 8'($random(seed));
    b = 8'($random(seed));
    c = 8'($random(seed));
    rx(a, 1'b1, 20);
    serial_line_model_i.send(b, 1'b1, 0);
    repeat (4) @(posedge REF_CLK);
    dma(a);
    rx(c, 1'b1, 10);
    dma(c);
    check({6'h00, IRQ_ERR, WAKE_REQ}, 8'h03, 8'h03);
    BREAK_CLEAR_ALLOW <= 1'b1;
    DEBUG_BREAK <= 1'b1;
    rd(STAT1_ADDR, 8'h28, 8'h08);
    rd(DATA_ADDR, 8'hFF, c);
    rd(STAT1_ADDR, 8'h08, 8'h00);
    DEBUG_BREAK <= 1'b0;
    rd(STAT1_ADDR, 8'h08, 8'h00);
    check({6'h00, IRQ_ERR, WAKE_REQ}, 8'h00, 8'h03);
    BREAK_CLEAR_ALLOW <= 1'b0;
    $display("test overrun done");
    a = 8'($random(seed));
    rx(a, 1'b1, 10);
    wr(CTRL2_ADDR, 8'h0C);
    rd(DATA_ADDR, 8'hFF, a);
    rd(STAT1_ADDR, 8'h20, 8'h20);
    rd(DATA_ADDR, 8'hFF, a);
    rd(STAT1_ADDR, 8'h20, 8'h00);
    wr(CTRL2_ADDR, 8'h2C);
    $display("test irq enable off done");
    WAIT_MODE <= 1'b1;
    rd(CTRL1_ADDR, 8'hFF, 8'h00);
    a = 8'($random(seed));
    rx(a, 1'b1, 10);
    dma(a);
    check({7'h00, WAKE_REQ}, 8'h00, 8'h01);
    WAIT_MODE <= 1'b0;
    STOP_MODE <= 1'b1;
    repeat (50) @(posedge REF_CLK);
    STOP_MODE <= 1'b0;
    rd(CTRL1_ADDR, 8'hFF, 8'h40);
    rd(CTRL3_ADDR, 8'h7F, 8'h28);
    $display("test low power done");
    wr(CTRL1_ADDR, 8'hC0);
    a = 8'($random(seed));
    wr(DATA_ADDR, a);
    wait_req();
    dma(a);
    $display("test loop done");
    wr(CTRL1_ADDR, 8'h00);
    rd(STAT1_ADDR, 8'hC0, 8'hC0);
    repeat (4) @(posedge REF_CLK);
    check({7'h00, SER_OUT_OE_N}, 8'h01, 8'h01);
    check({7'h00, SER_IN_PIN_OUT}, 8'h00, 8'h01);
    $display("test disable done");
    print_verdict();
  end
endmodule
`default_nettype wire
